// [hdl/seqled_pkg.sv]
/*
  Package for the sequential LED enable and fault control block.
  Assumes a 50 MHz system clock; the step period is a 16 ms parameter and strap values come from pins.
*/
`default_nettype none

package seqled_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SWITCHES     = 6;
  localparam int unsigned GROUP_SIZE       = 3;
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned STEP_PERIOD_MS   = 16;
  localparam int unsigned STEP_PERIOD_CYC  = (CLK_FREQ_HZ / 1000) * STEP_PERIOD_MS;
  localparam int unsigned STEP_CNT_W       = 24;
  localparam int unsigned STEP_IDX_W       = 3;
  localparam int unsigned SYNC_CNT_W       = 4;

  // ----------------------------------------------------------------
  // Strap field positions
  // ----------------------------------------------------------------
  localparam int unsigned DIR_BIT          = 3;
  localparam logic        DIR_DIM_DOWN     = 1'b0;
  localparam logic        DIR_DIM_UP       = 1'b1;

  // ----------------------------------------------------------------
  // Reset values (switch closed = 1, LED shunted)
  // ----------------------------------------------------------------
  localparam logic [5:0]  SW_ALL_OPEN      = 6'h00;
  localparam logic [5:0]  SW_ALL_CLOSED    = 6'h3F;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQLED_ST_POWERUP = 3'b000,
    SEQLED_ST_IDLE    = 3'b001,
    SEQLED_ST_WAIT    = 3'b010,
    SEQLED_ST_RUN     = 3'b011,
    SEQLED_ST_DONE    = 3'b100
  } seqled_state_t;

  // Open-drain pin as data and pull-down enable
  typedef struct packed {
    logic out;
    logic oe;
  } seqled_od_t;

  // Fault inputs from analog detectors
  typedef struct packed {
    logic open_led;
    logic short_led;
    logic thermal_shdn;
  } seqled_fault_t;

endpackage

`default_nettype wire

// [hdl/seqled_ctrl.sv]
/*
  Enable, sequencing and fault control for the six-switch LED bypass controller.
  Assumes pins are wired open-drain with external pull-ups; analog blocks supply
  ready and fault levels.
*/
// Summary of operation
// - While enable is sensed low every bypass switch stays open.
// - Enable is driven low from power-up until the charge pump and circuits are ready.
// - Sequencing starts only on a rising enable, using the strapped direction and the fixed step period.
// - The fault pin is pulled low as long as thermal shutdown, or an LED fault while enable is high, is present.
// - Fault causes are open LED, shorted LED or thermal shutdown.
// - LED fault detection is disabled while enable is low.
// - The device acts on the sensed enable level, not on its own drive.
// - Switch off lights its LEDs, switch on shunts them.
// - Switches form two groups of three that step as one sequence of six.
// - The sync line is a shared open-drain pin for chains beyond six segments.
// - Pulling enable low opens all switches at once for hazard lighting.
// - Dim down starts open and closes from switch six; dim up starts closed and opens from one.
// - The first switch changes at the end of the first step period, through the last.
// - Position N waits N sync rising edges, holds sync low while running, then releases.
`timescale 1ns/1ps
`default_nettype none

module seqled_ctrl
  import seqled_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rstn,
  // Analog status
  input  wire logic                    i_pump_ready,
  input  wire seqled_fault_t           i_fault,
  // Straps
  input  wire logic [3:0]              i_threshold_direction_strap,
  input  wire logic [3:0]              i_chain_position_strap,
  // Enable pin
  input  wire logic                    i_en_in,
  output logic                         o_en_out,
  output logic                         o_en_oe,
  // Sync pin
  input  wire logic                    i_sync_in,
  output logic                         o_sync_out,
  output logic                         o_sync_oe,
  // Fault pin
  output logic                         o_fault_out_n,
  output logic                         o_fault_oe,
  // Switch gates, 1 = closed
  output logic [NUM_SWITCHES-1:0]      o_switch_on,
  // Fault detection enable to analog
  output logic                         o_detect_en
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rstn;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]              en_sy;
    logic [1:0]              sync_sy;
    logic                    sync_prev;
    seqled_state_t           st;
    logic                    dir;
    logic [3:0]              pos;
    logic [SYNC_CNT_W-1:0]   sync_cnt;
    logic [STEP_CNT_W-1:0]   tick;
    logic [STEP_IDX_W-1:0]   step;
    logic [NUM_SWITCHES-1:0] sw;
    logic                    en_drv;
    logic                    sync_drv;
    logic                    fault_out_n;
    logic                    det;
  } seqled_regs_t;

  seqled_regs_t r_q;
  seqled_regs_t r_d;
  logic         en_hi;
  logic         sync_rise;
  logic         step_end;
  logic [NUM_SWITCHES-1:0] sw_pattern;
  logic [NUM_SWITCHES-1:0] sw_start;

  // Sensed levels after the second flop only
  assign en_hi     = r_q.en_sy[1];
  assign sync_rise = r_q.sync_sy[1] & ~r_q.sync_prev;
  assign step_end  = (r_q.tick == STEP_CNT_W'(STEP_CYCLES - 1));
  assign sw_start  = (r_q.dir == DIR_DIM_UP) ? SW_ALL_CLOSED : SW_ALL_OPEN;

  // Per-switch pattern after step+1 changes
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SWITCHES; gi++) begin : g_sw
      // Dim up opens from switch one; dim down closes from switch six
      always_comb begin
        if (r_q.dir == DIR_DIM_UP) begin
          sw_pattern[gi] = (gi > int'(r_q.step));
        end else begin
          sw_pattern[gi] = (gi >= NUM_SWITCHES - 1 - int'(r_q.step));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d           = r_q;
    r_d.en_sy     = {r_q.en_sy[0], i_en_in};
    r_d.sync_sy   = {r_q.sync_sy[0], i_sync_in};
    r_d.sync_prev = r_q.sync_sy[1];
    // Fault flag ORs the three causes, the two LED causes only while detection is live
    r_d.det = en_hi;
    r_d.fault_out_n = i_fault.thermal_shdn |
              (en_hi & (i_fault.open_led | i_fault.short_led));
    unique case (r_q.st)
      SEQLED_ST_POWERUP: begin
        r_d.en_drv = 1'b1;
        r_d.sw     = SW_ALL_OPEN;
        if (i_pump_ready) begin
          // Straps sampled once, when bias is up
          r_d.dir    = i_threshold_direction_strap[DIR_BIT];
          r_d.pos    = i_chain_position_strap;
          r_d.en_drv = 1'b0;
          r_d.st     = SEQLED_ST_IDLE;
        end
      end
      SEQLED_ST_IDLE: begin
        r_d.sw = SW_ALL_OPEN;
        if (en_hi) begin
          // Rising enable: load start pattern, then wait for chain turn
          r_d.sw       = sw_start;
          r_d.sync_cnt = '0;
          r_d.tick     = '0;
          r_d.step     = '0;
          r_d.st       = SEQLED_ST_WAIT;
        end
      end
      SEQLED_ST_WAIT: begin
        if (r_q.sync_cnt == r_q.pos) begin
          r_d.sync_drv = 1'b1;
          r_d.st       = SEQLED_ST_RUN;
        end else if (sync_rise) begin
          r_d.sync_cnt = r_q.sync_cnt + 1'b1;
        end
      end
      SEQLED_ST_RUN: begin
        r_d.tick = r_q.tick + 1'b1;
        if (step_end) begin
          // Each group of three is a slice of one pattern vector
          r_d.tick = '0;
          r_d.sw   = sw_pattern;
          r_d.step = r_q.step + 1'b1;
          if (r_q.step == STEP_IDX_W'(NUM_SWITCHES - 1)) begin
            r_d.sync_drv = 1'b0;
            r_d.st       = SEQLED_ST_DONE;
          end
        end
      end
      SEQLED_ST_DONE: begin
        // Hold end state until enable toggles
      end
      default: r_d.st = SEQLED_ST_POWERUP;
    endcase
    // Enable low: everything open, counters cleared, back to idle
    if (r_q.st != SEQLED_ST_POWERUP && !en_hi) begin
      r_d.sw       = SW_ALL_OPEN;
      r_d.sync_drv = 1'b0;
      r_d.sync_cnt = '0;
      r_d.tick     = '0;
      r_d.step     = '0;
      r_d.st       = SEQLED_ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_q        <= '0;
      r_q.st     <= SEQLED_ST_POWERUP;
      r_q.en_drv <= 1'b1;
      r_q.sw     <= SW_ALL_OPEN;
      // Sync idles high on its pull-up, so start there and see no false rise
      r_q.sync_sy   <= 2'h3;
      r_q.sync_prev <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops; open-drain outputs drive zero
  assign o_en_out      = 1'b0;
  assign o_en_oe       = r_q.en_drv;
  assign o_sync_out    = 1'b0;
  assign o_sync_oe     = r_q.sync_drv;
  assign o_fault_out_n = 1'b0;
  assign o_fault_oe    = r_q.fault_out_n;
  assign o_switch_on   = r_q.sw;
  assign o_detect_en   = r_q.det;

endmodule

`default_nettype wire

// [bench/seqled_link_model.sv]
/* Net model for the enable and sync lines of seqled_ctrl.
   Pull-up on each net; host and chained peers may pull low. */
`timescale 1ns/1ps
`default_nettype none
module seqled_link_model (
  // Pull-down enables of all parties
  input  wire logic i_en_oe,
  input  wire logic i_sync_oe,
  input  wire logic i_host_hold,
  input  wire logic i_peer_low,
  // Resolved net levels
  output logic      o_en_wire,
  output logic      o_sync_wire
);
  // Wired-AND nets: any party pulling low wins, so all devices see one level
  assign o_en_wire   = ~(i_en_oe | i_host_hold);
  assign o_sync_wire = ~(i_sync_oe | i_peer_low);
endmodule
`default_nettype wire

// [bench/seqled_ctrl_sva.sv]
/* Port checker for seqled_ctrl.
   Bound to each instance; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module seqled_ctrl_sva
  import seqled_pkg::*;
#(parameter int unsigned STEP_CYCLES = STEP_PERIOD_CYC) (
  // Inputs
  input wire logic          i_clk_sys,
  input wire logic          i_rstn,
  input wire logic          i_pump_ready,
  input wire seqled_fault_t i_fault,
  input wire logic [3:0]    i_threshold_direction_strap,
  input wire logic [3:0]    i_chain_position_strap,
  input wire logic          i_en_in,
  input wire logic          i_sync_in,
  // Outputs
  input wire logic          o_en_out,
  input wire logic          o_en_oe,
  input wire logic          o_sync_out,
  input wire logic          o_sync_oe,
  input wire logic          o_fault_out_n,
  input wire logic          o_fault_oe,
  input wire logic [5:0]    o_switch_on,
  input wire logic          o_detect_en
);
  // Cycles since the switches last moved; unknown until the first move
  logic [23:0] gap_q;
  always_ff @(posedge i_clk_sys) gap_q <= $changed(o_switch_on) ? 24'h1 : gap_q + 24'h1;
  // Margins of three and four samples cover the two-flop input path
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence en_low3; !i_en_in [*3]; endsequence
  sequence en_high4; i_en_in [*4]; endsequence
  sequence step_seen; $changed(o_switch_on) && $past(o_sync_oe); endsequence
  chk_open_low: assert property (en_low3 |=> o_switch_on == SW_ALL_OPEN)
    else $error("switches closed while enable low");
  chk_quiet_low: assert property (en_low3 |=> !o_detect_en && !o_sync_oe)
    else $error("detect or sync active while enable low");
  chk_pump_release: assert property (i_pump_ready [*5] |=> !o_en_oe)
    else $error("enable still held after pump ready");
  chk_fault_set: assert property (!o_en_oe && (i_fault.thermal_shdn || ((i_fault.open_led
    || i_fault.short_led) && i_en_in && $past(i_en_in) && $past(i_en_in, 2))) |=> o_fault_oe)
    else $error("fault pin not pulled low");
  chk_fault_clear: assert property (i_fault == 3'h0 |=> !o_fault_oe)
    else $error("fault pin low without cause");
  chk_led_masked: assert property (en_low3 ##0 !i_fault.thermal_shdn |=> !o_fault_oe)
    else $error("led fault reported while enable low");
  chk_step_order: assert property (en_high4 ##0 step_seen |-> o_switch_on ==
    (i_threshold_direction_strap[DIR_BIT] ? {$past(o_switch_on[4:0]), 1'b0}
    : {1'b1, $past(o_switch_on[5:1])})) else $error("wrong switch moved");
  chk_step_gap: assert property (en_high4 ##0 step_seen ##0 $past(o_switch_on) != 6'h00
    && $past(o_switch_on) != 6'h3F |-> gap_q == STEP_CYCLES) else $error("step period wrong");
endmodule
bind seqled_ctrl seqled_ctrl_sva #(.STEP_CYCLES(STEP_CYCLES)) u_seqled_ctrl_sva (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_pump_ready(i_pump_ready), .i_fault(i_fault),
  .i_threshold_direction_strap(i_threshold_direction_strap),
  .i_chain_position_strap(i_chain_position_strap), .i_en_in(i_en_in), .i_sync_in(i_sync_in),
  .o_en_out(o_en_out), .o_en_oe(o_en_oe), .o_sync_out(o_sync_out), .o_sync_oe(o_sync_oe),
  .o_fault_out_n(o_fault_out_n), .o_fault_oe(o_fault_oe), .o_switch_on(o_switch_on),
  .o_detect_en(o_detect_en));
`default_nettype wire

// [bench/seqled_ctrl_test.sv]
/* Self-checking bench for seqled_ctrl.
   Link model resolves the enable and sync nets; checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module seqled_ctrl_test;
  import seqled_pkg::*;
  localparam int unsigned STEP = 10;
  // Design pins under their port names, so the instance connects by name
  logic          i_clk_sys = 1'b0, i_rstn = 1'b0, i_pump_ready = 1'b0, i_en_in, i_sync_in;
  seqled_fault_t i_fault = 3'h0;
  logic [3:0]    i_threshold_direction_strap = 4'h0, i_chain_position_strap = 4'h0;
  logic          o_en_out, o_en_oe, o_sync_out, o_sync_oe, o_fault_out_n, o_fault_oe;
  logic          o_detect_en, host_hold = 1'b1, peer_low = 1'b0;
  logic [5:0]    o_switch_on;
  logic [31:0]   lfsr_q = 32'h16B3;
  int            mismatches = 0, total_checks = 0;
  // Design, with a short step period, and the net model
  seqled_ctrl #(.STEP_CYCLES(STEP)) u_seqled_ctrl (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_pump_ready(i_pump_ready), .i_fault(i_fault),
    .i_threshold_direction_strap(i_threshold_direction_strap),
    .i_chain_position_strap(i_chain_position_strap), .i_en_in(i_en_in), .o_en_out(o_en_out),
    .o_en_oe(o_en_oe), .i_sync_in(i_sync_in), .o_sync_out(o_sync_out), .o_sync_oe(o_sync_oe),
    .o_fault_out_n(o_fault_out_n), .o_fault_oe(o_fault_oe), .o_switch_on(o_switch_on),
    .o_detect_en(o_detect_en));
  seqled_link_model u_seqled_link_model (.i_en_oe(o_en_oe), .i_sync_oe(o_sync_oe),
    .i_host_hold(host_hold), .i_peer_low(peer_low), .o_en_wire(i_en_in), .o_sync_wire(i_sync_in));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  // Random source and expected fault pin
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic fault_out_n(input seqled_fault_t f, input logic en);
    return f.thermal_shdn | (en & (f.open_led | f.short_led));
  endfunction
  // Inputs always change 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Power-up under host hold, then animation; an abort pass first if asked
  task automatic run(input logic d, input logic [3:0] p, input int aborts);
    i_rstn = 1'b0;
    i_pump_ready = 1'b0;
    host_hold = 1'b1;
    i_threshold_direction_strap = {d, lfsr_q[2:0]};
    i_chain_position_strap = p;
    tick(10);
    i_rstn = 1'b1;
    tick(20);
    `CHK("en_oe_early", 1'b1, o_en_oe)
    i_pump_ready = 1'b1;
    tick(6);
    `CHK("held", 7'h00, {o_en_oe, o_switch_on})
    `CHK("od_data", 3'h0, {o_en_out, o_sync_out, o_fault_out_n})
    for (int k = aborts; k >= 0; k--) begin
      host_hold = 1'b0;
      tick(5);
      `CHK("start", {{6{d}}, p == 4'h0}, {o_switch_on, o_sync_oe})
      repeat (2 * p) begin
        peer_low = ~peer_low;
        tick(3);
      end
      tick(4);
      `CHK("sync", 2'b10, {o_sync_oe, i_sync_in})
      if (k > 0) begin
        tick(2 * STEP);
        host_hold = 1'b1;
        tick(200);
        `CHK("abort", 8'h00, {o_switch_on, o_sync_oe, o_detect_en})
      end
    end
    tick(7 * STEP);
    `CHK("end", {{6{!d}}, 2'b01}, {o_switch_on, o_sync_oe, o_detect_en})
  endtask
  // Both directions, chain positions, abort, then random faults and enable
  initial begin
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      run(i[0], (i < 2) ? 4'h0 : {2'b00, lfsr_q[1:0] | 2'b01}, (i == 1) ? 1 : 0);
      repeat (16) begin
        lfsr_q = lfsr(lfsr_q);
        i_fault = lfsr_q[2:0];
        host_hold = lfsr_q[3];
        tick(4);
        `CHK("fault", fault_out_n(i_fault, !host_hold), o_fault_oe)
      end
      $display("test %0d done", i);
    end
    stop_test();
  end
  // Watchdog well beyond the expected run of about 1000 cycles
  initial begin
    tick(6000);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
